//--- core/qbp_port_pair.sv
/*
  Holds the two quasi-bidirectional ports (upper-address port and
  lower-function port), their alternate-function muxing, the program
  source select sampling and the address-latch pulse per machine cycle.
  Assumes the core supplies latch writes, alternate outputs and bus
  controls synchronous to clk_sys; pins are resolved outside from the
  strong-high/strong-low enables plus an external weak pullup view.
*/
// How it works
// - upper port resets high, weak pullup only
// - written 0 holds strong pulldown until 1
// - 0-to-1 write gives brief strong high
// - upper port drives external address high byte
// - lower port resets to 1, weak pullup
// - lower bits: serial, interrupts, timer inputs
// - bits 6,7 are write, read strobes
// - select low fetches external program memory
// - on-chip data RAM access never blocked
// - four clocks per cycle, one latch pulse
`timescale 1ns/1ps
module qbp_port_pair
  import qbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // software latch writes
  input wire logic upper_wr,
  input wire logic [qbp_pkg::PORT_W-1:0] upper_wdata,
  input wire logic alt_wr,
  input wire logic [qbp_pkg::PORT_W-1:0] alt_wdata,
  // external bus cycle from the core
  input wire logic ext_addr_en,
  input wire logic [qbp_pkg::PORT_W-1:0] external_addr_high_byte,
  input wire logic serial0_tx_out,
  input wire logic data_wr_strobe_n,
  input wire logic data_rd_strobe_n,
  // pin level as seen on the board
  input wire logic [qbp_pkg::PORT_W-1:0] upper_pin_in,
  input wire logic [qbp_pkg::PORT_W-1:0] alt_pin_in,
  input wire logic program_source_select_n,
  // pin drive: strong high enable, strong low enable (weak pullup implied)
  output logic [qbp_pkg::PORT_W-1:0] upper_pin_hi_en,
  output logic [qbp_pkg::PORT_W-1:0] upper_pin_lo_en,
  output logic [qbp_pkg::PORT_W-1:0] alt_pin_hi_en,
  output logic [qbp_pkg::PORT_W-1:0] alt_pin_lo_en,
  // values read back by the core
  output logic [qbp_pkg::PORT_W-1:0] upper_latch,
  output logic [qbp_pkg::PORT_W-1:0] alt_latch,
  output logic [qbp_pkg::PORT_W-1:0] upper_pin_read,
  output logic [qbp_pkg::PORT_W-1:0] alt_pin_read,
  output logic serial0_rx_in,
  output logic ext_irq_zero_in,
  output logic ext_irq_one_in,
  output logic timer_zero_count_in,
  output logic timer_one_count_in,
  output logic fetch_external,
  output logic data_ram_enable,
  output logic addr_latch_en
);
  import qbp_pkg::*;

  // ----------------------------------------
  // port latches
  // ----------------------------------------
  logic [PORT_W-1:0] up_q;
  logic [PORT_W-1:0] al_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      up_q <= PORT_RESET;
      al_q <= PORT_RESET;
    end
    else
    begin
      if (upper_wr)
        up_q <= upper_wdata;
      if (alt_wr)
        al_q <= alt_wdata;
    end
  end

  // ----------------------------------------
  // effective pin values
  // ----------------------------------------
  logic [PORT_W-1:0] up_val;
  logic [PORT_W-1:0] al_alt;
  logic [PORT_W-1:0] al_val;

  // address byte replaces latch during external cycles
  assign up_val = ext_addr_en ? external_addr_high_byte : up_q;
  // inputs-only alternate bits return 1 so the latch alone decides
  assign al_alt = {data_rd_strobe_n, data_wr_strobe_n, 4'hf, serial0_tx_out, 1'b1};
  // alternate output gated by latch 1; bit mapping
  assign al_val = al_q & al_alt;

  // ----------------------------------------
  // per-pin drive state machine
  // ----------------------------------------
  logic [PORT_W-1:0] up_lo_d;
  logic [PORT_W-1:0] up_hi_d;
  logic [PORT_W-1:0] al_lo_d;
  logic [PORT_W-1:0] al_hi_d;

  genvar gi;
  generate
    for (gi = 0; gi < 2 * PORT_W; gi++)
    begin : g_pin
      qbp_pin_e st_q;
      qbp_pin_e st_d;
      logic [1:0] cnt_q;
      logic [1:0] cnt_d;
      logic want;
      assign want = (gi < PORT_W) ? up_val[gi % PORT_W] : al_val[gi % PORT_W];

      // low holds; rising goes through a short boost
      always_comb
      begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
          QBP_PIN_WEAK:
            if (!want)
              st_d = QBP_PIN_LOW;
          QBP_PIN_LOW:
            if (want)
            begin
              st_d = QBP_PIN_BOOST;
              cnt_d = BOOST_CYC - 2'h1;
            end
          QBP_PIN_BOOST:
            if (!want)
              st_d = QBP_PIN_LOW;
            else if (cnt_q == 2'h0)
              st_d = QBP_PIN_WEAK;
            else
              cnt_d = cnt_q - 2'h1;
          default:
            st_d = QBP_PIN_WEAK;
        endcase
      end

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          st_q <= QBP_PIN_WEAK;
          cnt_q <= 2'h0;
        end
        else
        begin
          st_q <= st_d;
          cnt_q <= cnt_d;
        end
      end

      if (gi < PORT_W)
      begin : g_up
        assign up_lo_d[gi] = (st_d == QBP_PIN_LOW);
        assign up_hi_d[gi] = (st_d == QBP_PIN_BOOST);
      end
      else
      begin : g_al
        assign al_lo_d[gi - PORT_W] = (st_d == QBP_PIN_LOW);
        assign al_hi_d[gi - PORT_W] = (st_d == QBP_PIN_BOOST);
      end
    end
  endgenerate

  // ----------------------------------------
  // machine cycle and address-latch pulse
  // ----------------------------------------
  logic [1:0] mc_q;
  logic ale_d;
  // one pulse on phase 0 of each 4-clock cycle
  assign ale_d = (mc_q == MC_LAST);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      mc_q <= 2'h0;
    else
      mc_q <= (mc_q == MC_LAST) ? 2'h0 : mc_q + 2'h1;
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // pin inputs are registered once; they are taken as synchronous
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      upper_pin_hi_en <= '0;
      upper_pin_lo_en <= '0;
      alt_pin_hi_en <= '0;
      alt_pin_lo_en <= '0;
      upper_latch <= PORT_RESET;
      alt_latch <= PORT_RESET;
      upper_pin_read <= PORT_RESET;
      alt_pin_read <= PORT_RESET;
      serial0_rx_in <= 1'b1;
      ext_irq_zero_in <= 1'b1;
      ext_irq_one_in <= 1'b1;
      timer_zero_count_in <= 1'b1;
      timer_one_count_in <= 1'b1;
      fetch_external <= 1'b0;
      data_ram_enable <= 1'b1;
      addr_latch_en <= 1'b0;
    end
    else
    begin
      upper_pin_hi_en <= up_hi_d;
      upper_pin_lo_en <= up_lo_d;
      alt_pin_hi_en <= al_hi_d;
      alt_pin_lo_en <= al_lo_d;
      upper_latch <= up_q;
      alt_latch <= al_q;
      upper_pin_read <= upper_pin_in;
      alt_pin_read <= alt_pin_in;
      // input alternate functions taken from pins
      serial0_rx_in <= alt_pin_in[ALT_RX_BIT];
      ext_irq_zero_in <= alt_pin_in[ALT_IRQ0_BIT];
      ext_irq_one_in <= alt_pin_in[ALT_IRQ1_BIT];
      timer_zero_count_in <= alt_pin_in[ALT_T0_BIT];
      timer_one_count_in <= alt_pin_in[ALT_T1_BIT];
      // low select means external program fetch
      fetch_external <= !program_source_select_n;
      data_ram_enable <= 1'b1;
      addr_latch_en <= ale_d;
    end
  end
endmodule

//--- core/qbp_pkg.sv
/*
  Package for the quasi-bidirectional port pair: widths, reset values,
  alternate-function bit positions and timing counts.
  Assumes a single 25 MHz system clock, one clock per oscillator clock.
*/
package qbp_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] PORT_RESET = 8'hff;
  // alternate-function bit positions on the lower-function port
  localparam int ALT_RX_BIT = 0;
  localparam int ALT_TX_BIT = 1;
  localparam int ALT_IRQ0_BIT = 2;
  localparam int ALT_IRQ1_BIT = 3;
  localparam int ALT_T0_BIT = 4;
  localparam int ALT_T1_BIT = 5;
  localparam int ALT_WR_BIT = 6;
  localparam int ALT_RD_BIT = 7;
  // oscillator clocks per machine cycle
  localparam int MC_CLOCKS = 4;
  localparam logic [1:0] MC_LAST = 2'h3;
  // strong pull-high pulse after a 0-to-1 write, as a time and a count
  localparam int CLK_NS = 40;
  localparam int BOOST_NS = 40;
  localparam int BOOST_CYC_I = (BOOST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] BOOST_CYC = 2'(BOOST_CYC_I < 1 ? 1 : BOOST_CYC_I);
  typedef enum logic [1:0] {
    QBP_PIN_WEAK = 2'b00,
    QBP_PIN_BOOST = 2'b01,
    QBP_PIN_LOW = 2'b10
  } qbp_pin_e;
endpackage

//--- verif/qbp_properties.sv
/* checker for the port pair pins and timing
   assumes it is bound to the port pair top */
`timescale 1ns/1ps
module qbp_properties (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] upper_pin_hi_en,
  input wire logic [7:0] upper_pin_lo_en,
  input wire logic [7:0] alt_pin_hi_en,
  input wire logic [7:0] alt_pin_lo_en,
  input wire logic [7:0] alt_latch,
  input wire logic [7:0] alt_pin_in,
  input wire logic serial0_rx_in,
  input wire logic program_source_select_n,
  input wire logic fetch_external,
  input wire logic data_ram_enable,
  input wire logic addr_latch_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_drive_excl: assert property (
    ((alt_pin_lo_en & alt_pin_hi_en) | (upper_pin_lo_en & upper_pin_hi_en)) == 8'h00)
    else $error("strong high and low on together");
  a_boost_once: assert property (
    (alt_pin_hi_en & $past(alt_pin_hi_en)) == 8'h00) else $error("boost over one cycle");
  a_boost_cause: assert property (
    $fell(alt_pin_lo_en[0]) |-> alt_pin_hi_en[0]) else $error("no boost after low");
  a_lo_latch: assert property (
    (alt_pin_lo_en & 8'h3d) == (~alt_latch & 8'h3d)) else $error("pulldown off latch");
  a_ale_gap: assert property (
    addr_latch_en |=> !addr_latch_en [*3] ##1 addr_latch_en) else $error("latch pulse gap");
  a_fetch_sel: assert property (
    $past(rstn) |-> fetch_external == !$past(program_source_select_n))
    else $error("fetch source wrong");
  a_ram_on: assert property (
    data_ram_enable) else $error("data ram blocked");
  a_rx_follow: assert property (
    $past(rstn) |-> serial0_rx_in == $past(alt_pin_in[0])) else $error("rx not sampled");
  c_boost: cover property ($rose(alt_pin_hi_en[0]));
  c_fetch: cover property (fetch_external);
  c_strobe: cover property (alt_pin_lo_en[6]);
endmodule

//--- verif/qbp_pin_model.sv
/* board side of one port: weak pullup plus external pull-downs
   assumes active-high strong enables from the port */
`timescale 1ns/1ps
module qbp_pin_model (
  input wire logic [7:0] hi_en,
  input wire logic [7:0] lo_en,
  input wire logic [7:0] ext_low,
  output logic [7:0] pin
);
  // strong low wins; weak pullup loses to an outside driver
  assign pin = (hi_en | ~ext_low) & ~lo_en;
endmodule

//--- verif/quasi_bidir_port_pair_tb.sv
/* self-checking bench for the port pair
   assumes the pin model on both ports and one 25 MHz clock */
`timescale 1ns/1ps
module quasi_bidir_port_pair_tb;
  logic clk_sys, rstn, upper_wr, alt_wr, ext_addr_en, serial0_tx_out;
  logic data_wr_strobe_n, data_rd_strobe_n, program_source_select_n;
  logic [7:0] upper_wdata, alt_wdata, external_addr_high_byte, upper_pin_in, alt_pin_in;
  logic [7:0] upper_pin_hi_en, upper_pin_lo_en, alt_pin_hi_en, alt_pin_lo_en;
  logic [7:0] upper_latch, alt_latch, upper_pin_read, alt_pin_read, up_ext, alt_ext;
  logic serial0_rx_in, ext_irq_zero_in, ext_irq_one_in, timer_zero_count_in;
  logic timer_one_count_in, fetch_external, data_ram_enable, addr_latch_en;
  int err_total = 0, checks_done = 0, cyc = 0, ale_n = 0;
  // rows: written byte, expected pulldowns
  logic [15:0] rows [5] = '{16'h00ff, 16'hfe01, 16'h5aa5, 16'h7f80, 16'hff00};
  qbp_port_pair i_dut (.clk_sys, .rstn, .upper_wr, .upper_wdata, .alt_wr, .alt_wdata,
    .ext_addr_en, .external_addr_high_byte, .serial0_tx_out, .data_wr_strobe_n,
    .data_rd_strobe_n, .upper_pin_in, .alt_pin_in, .program_source_select_n,
    .upper_pin_hi_en, .upper_pin_lo_en, .alt_pin_hi_en, .alt_pin_lo_en, .upper_latch,
    .alt_latch, .upper_pin_read, .alt_pin_read, .serial0_rx_in, .ext_irq_zero_in,
    .ext_irq_one_in, .timer_zero_count_in, .timer_one_count_in, .fetch_external,
    .data_ram_enable, .addr_latch_en);
  qbp_pin_model i_up (.hi_en(upper_pin_hi_en), .lo_en(upper_pin_lo_en), .ext_low(up_ext),
    .pin(upper_pin_in));
  qbp_pin_model i_alt (.hi_en(alt_pin_hi_en), .lo_en(alt_pin_lo_en), .ext_low(alt_ext),
    .pin(alt_pin_in));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    {upper_wr, alt_wr, upper_wdata, alt_wdata} = {2'b11, d, d};
    tick(1);
    {upper_wr, alt_wr} = 2'b00;
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // clock, hang guard and latch pulse count
  initial
  begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      conclude();
    end
  end
  always @(negedge clk_sys) if (addr_latch_en === 1'b1) ale_n++;
  initial
  begin
    {rstn, upper_wr, alt_wr, ext_addr_en, upper_wdata, alt_wdata} = 0;
    {serial0_tx_out, data_wr_strobe_n, data_rd_strobe_n, program_source_select_n} = 4'hf;
    {external_addr_high_byte, up_ext, alt_ext} = 0;
    tick(10);
    rstn = 1;
    chk("up_drive", 8'h00, upper_pin_lo_en | upper_pin_hi_en);
    chk("alt_latch", 8'hff, alt_latch);
    foreach (rows[i])
    begin
      wr(rows[i][15:8]);
      tick(3);
      chk("alt_lo", rows[i][7:0], alt_pin_lo_en);
      chk("up_lo", rows[i][7:0], upper_pin_lo_en);
      chk("alt_read", rows[i][15:8], alt_pin_read);
      chk("up_latch", rows[i][15:8], upper_latch);
    end
    wr(8'h00);
    tick(2);
    wr(8'hff);
    tick(1);
    chk("boost", 8'hff, alt_pin_hi_en);
    chk("up_boost", 8'hff, upper_pin_hi_en);
    tick(1);
    chk("boost_end", 8'h00, alt_pin_hi_en);
    chk("up_boost_end", 8'h00, upper_pin_hi_en);
    {serial0_tx_out, data_wr_strobe_n, data_rd_strobe_n} = 3'h0;
    tick(3);
    chk("alt_out", 8'hc2, alt_pin_lo_en);
    {serial0_tx_out, data_wr_strobe_n, data_rd_strobe_n} = 3'h7;
    wr(8'h3d);
    tick(3);
    chk("alt_gate", 8'hc2, alt_pin_lo_en);
    wr(8'hff);
    ext_addr_en = 1;
    external_addr_high_byte = 8'h3c;
    tick(3);
    chk("addr_hi", 8'hc3, upper_pin_lo_en);
    ext_addr_en = 0;
    {alt_ext, up_ext} = 16'h3d0f;
    tick(3);
    chk("alt_in", 8'h00, {3'h0, serial0_rx_in, ext_irq_zero_in, ext_irq_one_in,
      timer_zero_count_in, timer_one_count_in});
    chk("up_read", 8'hf0, upper_pin_read);
    {alt_ext, up_ext, program_source_select_n} = 17'h0;
    tick(3);
    chk("fetch", 8'h01, {7'h0, fetch_external});
    chk("ram", 8'h01, {7'h0, data_ram_enable});
    program_source_select_n = 1;
    ale_n = 0;
    tick(40);
    chk("ale", 8'h0a, 8'(ale_n));
    // mid-run reset: pulldowns drop at once, no boost on release
    wr(8'h00);
    tick(2);
    rstn = 0;
    tick(1);
    chk("rst_lo", 8'h00, alt_pin_lo_en | upper_pin_lo_en);
    chk("rst_latch", 8'hff, upper_latch);
    rstn = 1;
    tick(3);
    chk("rel_drive", 8'h00, upper_pin_lo_en | upper_pin_hi_en);
    chk("rel_alt_latch", 8'hff, alt_latch);
    conclude();
  end
endmodule
bind qbp_port_pair qbp_properties i_chk (.clk_sys, .rstn, .upper_pin_hi_en,
  .upper_pin_lo_en, .alt_pin_hi_en, .alt_pin_lo_en, .alt_latch, .alt_pin_in,
  .serial0_rx_in, .program_source_select_n, .fetch_external, .data_ram_enable,
  .addr_latch_en);
